// *** rtl/cpva_cfg.svh ***
// constants for the cascaded priority vector array
`ifndef CPVA_CFG_SVH
`define CPVA_CFG_SVH
`define CPVA_LEVELS_PER_STAGE 8
`define CPVA_STAGES           2
`define CPVA_MAX_STAGES       5
`define CPVA_LEVELS           16
`define CPVA_RESTART_OPCODE   8'hff
`define CPVA_DISPATCH_ADDR    8'h38
`define CPVA_VEC_UPPER_BIT    7
`define CPVA_VEC_LOWER_BIT    6
`define CPVA_VEC_LEVEL_LSB    3
`define CPVA_STATUS_RESET     4'h0
`endif

// *** rtl/cpva_pkg.sv ***
// types for the cascaded priority vector array
package cpva_pkg;
    // processor-side read strobes
    typedef struct packed {
        logic ack_read;
        logic port_read;
    } cpva_rd_s;
    // per-stage status word: group-select bit and three level bits
    typedef struct packed {
        logic       group_select_n;
        logic [2:0] level_n;
    } cpva_status_s;
    typedef logic [2:0] cpva_code_t;
endpackage

// *** rtl/cpva_top.sv ***
// sixteen-level cascaded priority vector array with restart and vector answers
`timescale 1ns/1ps
`include "cpva_cfg.svh"
module cpva_top
    import cpva_pkg::*;
(
    // clock and reset
    input  wire logic                                   REF_CLK_IN,
    input  wire logic                                   RSTN_IN,
    // interrupt requests, level 15 highest
    input  wire logic [`CPVA_LEVELS-1:0]                REQ_N_IN,
    input  wire logic                                   INTERRUPT_ENABLE_INPUT_IN,
    // status load per stage
    input  wire logic [`CPVA_STAGES-1:0]                STATUS_LOAD_STROBE_N_IN,
    input  wire cpva_status_s                           STATUS_DATA_IN,
    // processor read strobes
    input  wire cpva_rd_s                               RD_IN,
    // interrupt and data bus
    output logic                                        INT_OUT,
    output logic [7:0]                                  DATA_OUT,
    output logic                                        DATA_OE_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // per-stage state
    localparam int NS = `CPVA_STAGES;

    logic [NS-1:0]      stage_pending;
    logic [NS:0]        enable_this_level_group;
    logic [NS-1:0]      enable_level_read_n;
    cpva_code_t         level_code_n [NS];
    logic [7:0]         req_latch_reg [NS];
    cpva_status_s       status_reg [NS];
    logic               interrupt_disable_flag_reg;
    logic               int_reg;
    logic [7:0]         vector_reg;
    logic [7:0]         vector_next;
    logic               any_int;

    // highest set bit index of a request byte
    function automatic cpva_code_t top_level(input logic [7:0] r);
        cpva_code_t idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (r[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // first stage is permitted unconditionally
    assign enable_this_level_group[0] = 1'b1;

    generate
        for (genvar s = 0; s < NS; s++)
        begin : g_stage
            // stage s serves levels from the top down: stage 0 holds 15..8
            localparam int BASE = (NS - 1 - s) * `CPVA_LEVELS_PER_STAGE;
            logic [7:0] masked;
            logic       above;

            // requests enter only while the disable flag is clear
            always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
            begin
                if (!RSTN_IN)
                    req_latch_reg[s] <= 8'h00;
                else if (!interrupt_disable_flag_reg)
                    req_latch_reg[s] <= ~REQ_N_IN[BASE +: 8];
            end

            // status word, loaded by the stage's strobe
            always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
            begin
                if (!RSTN_IN)
                    status_reg[s] <= `CPVA_STATUS_RESET;
                else if (!STATUS_LOAD_STROBE_N_IN[s])
                    status_reg[s] <= STATUS_DATA_IN;
            end

            // only levels above the current status, unless the comparison is bypassed
            always_comb
            begin
                masked = 8'h00;
                for (int i = 0; i < 8; i++)
                begin
                    above = (3'(i) > ~status_reg[s].level_n);
                    masked[i] = req_latch_reg[s][i] & (above | ~status_reg[s].group_select_n);
                end
            end

            assign stage_pending[s] = |masked & enable_this_level_group[s];
            // ripple: next stage allowed only when nothing is pending here
            assign enable_this_level_group[s+1] = enable_this_level_group[s] & ~(|masked);
            assign enable_level_read_n[s] = ~enable_this_level_group[s];
            // complemented level, released (all ones) when not read
            assign level_code_n[s] = enable_level_read_n[s] ? 3'h7 : ~top_level(masked);

            // a frozen latch keeps the served level from being replaced while it is answered
            a_latch_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
                interrupt_disable_flag_reg |=> $stable(req_latch_reg[s])) else $error("latch moved while disabled");
        end
    endgenerate

    assign any_int = |stage_pending & INTERRUPT_ENABLE_INPUT_IN;

    ////////////////////////////////////////////////////////////////////////////////
    // vector byte from the winning stage; wired-and of open-collector codes
    always_comb
    begin
        vector_next = 8'h00;
        for (int s = 0; s < NS; s++)
        begin
            if (stage_pending[s] && vector_next == 8'h00)
            begin
                vector_next[`CPVA_VEC_UPPER_BIT] = (s == 0);
                vector_next[`CPVA_VEC_LOWER_BIT] = (s != 0);
                vector_next[5:3] = level_code_n[s];
            end
        end
        vector_next[2:0] = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // single-cycle interrupt and disable flag; load clears flag, new interrupt wins
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            int_reg <= 1'b0;
            interrupt_disable_flag_reg <= 1'b0;
        end
        else
        begin
            int_reg <= any_int & ~interrupt_disable_flag_reg;
            if (any_int & ~interrupt_disable_flag_reg)
                interrupt_disable_flag_reg <= 1'b1;
            else if (!(&STATUS_LOAD_STROBE_N_IN))
                interrupt_disable_flag_reg <= 1'b0;
        end
    end

    // vector captured with the interrupt so it stays stable for the port read
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            vector_reg <= 8'h00;
        else if (any_int & ~interrupt_disable_flag_reg)
            vector_reg <= vector_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus answer, acknowledge takes precedence over port read
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            DATA_OUT    <= 8'h00;
            DATA_OE_OUT <= 1'b0;
        end
        else
        begin
            DATA_OE_OUT <= RD_IN.ack_read | RD_IN.port_read;
            if (RD_IN.ack_read)
                DATA_OUT <= `CPVA_RESTART_OPCODE;
            else if (RD_IN.port_read)
                DATA_OUT <= vector_reg;
            else
                DATA_OUT <= 8'h00;
        end
    end

    assign INT_OUT = int_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_int_sets_flag: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        INT_OUT |-> interrupt_disable_flag_reg) else $error("flag not set with interrupt");
    a_int_single: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        INT_OUT |=> !INT_OUT) else $error("interrupt longer than one cycle");
    a_int_gate_en: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        !INTERRUPT_ENABLE_INPUT_IN |=> !INT_OUT) else $error("interrupt while disabled");
    a_ack_opcode: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        RD_IN.ack_read |=> DATA_OE_OUT && DATA_OUT == 8'hff) else $error("bad restart opcode");
    a_port_vector: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        RD_IN.port_read && !RD_IN.ack_read |=> DATA_OUT == $past(vector_reg)) else $error("bad vector");
    a_low_bits_zero: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        vector_reg[2:0] == 3'h0) else $error("vector low bits set");
    a_group_bits: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        INT_OUT |-> vector_reg[7] != vector_reg[6]) else $error("group bits wrong");
    a_bus_release: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        !RD_IN.ack_read && !RD_IN.port_read |=> !DATA_OE_OUT) else $error("bus not released");
    a_ripple_block: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        stage_pending[0] |-> !enable_this_level_group[1]) else $error("ripple not blocked");
    // only one stage may ever claim the vector, else the wired codes would mix
    a_one_winner: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        $onehot0(stage_pending)) else $error("two stages pending at once");
    a_chain_idle: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        enable_this_level_group[NS] |-> stage_pending == '0) else $error("permission passed while pending");
    c_status_masked: cover property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (|req_latch_reg[1]) && status_reg[1].group_select_n && !stage_pending[1]);
    c_int_high: cover property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) INT_OUT && vector_reg[7]);
    c_int_low: cover property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) INT_OUT && vector_reg[6]);
    c_ack_then_port: cover property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        RD_IN.ack_read ##[1:20] RD_IN.port_read);
endmodule

// *** tb/cpva_host_model.sv ***
// host-side partner that answers each interrupt with an acknowledge read and a port read
`timescale 1ns/1ps
module cpva_host_model
    import cpva_pkg::*;
(
    // clock and bus from the array
    input  wire logic       clk_in,
    input  wire logic       int_in,
    input  wire logic [7:0] data_in,
    input  wire logic       oe_in,
    // strobes and captured bytes
    output cpva_rd_s        rd_out,
    output logic [7:0]      ack_byte_out,
    output logic [7:0]      vec_byte_out,
    output logic [15:0]     entry_out,
    output int              answers_out
);
    localparam logic [7:0] BASE_HI = 8'h20; // service area, arbitrary
    initial
    begin
        rd_out = '0;
        answers_out = 0;
    end
    ////////////////////////////////////////////////////////////////
    // wait for a released bus first, else a stale byte could be taken
    task automatic read_byte(input bit ack, output logic [7:0] b);
        for (int n = 0; n < 8 && oe_in !== 1'b0; n++) @(negedge clk_in);
        rd_out.ack_read = ack;
        rd_out.port_read = !ack;
        for (int n = 0; n < 8; n++)
        begin
            @(negedge clk_in);
            if (oe_in === 1'b1) break;
        end
        b = data_in;
        rd_out = '0;
    endtask
    // acknowledge, then read the vector and jump into the service area
    always @(negedge clk_in)
    begin
        if (int_in === 1'b1)
        begin
            read_byte(1'b1, ack_byte_out);
            read_byte(1'b0, vec_byte_out);
            entry_out = {BASE_HI, vec_byte_out};
            answers_out++;
        end
    end
endmodule

// *** tb/cpva_top_tb.sv ***
// self-checking bench for the cascaded priority vector array
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module cpva_top_tb
    import cpva_pkg::*;
;
    logic         ref_clk = 1'b0;
    logic         rstn    = 1'b0;
    logic         en      = 1'b0;
    logic [15:0]  req_n   = 16'hffff;
    logic [1:0]   load_n  = 2'h3;
    cpva_status_s status  = '0;
    cpva_rd_s     rd;
    logic         int_w;
    logic         oe;
    logic [7:0]   data, ack_b, vec_b, exp_vec;
    logic [15:0]  entry;
    logic [7:0]   exp_q [$];
    int           answers, prev, w, int_cnt, error_cnt, comparisons;
    int           seed = 83966;
    always #2 ref_clk = ~ref_clk;
    // count interrupt pulses, one expected per serviced request
    always @(posedge ref_clk)
    begin
        if (int_w === 1'b1) int_cnt++;
    end
    cpva_top cpva_top_i (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .REQ_N_IN(req_n),
        .INTERRUPT_ENABLE_INPUT_IN(en), .STATUS_LOAD_STROBE_N_IN(load_n), .STATUS_DATA_IN(status),
        .RD_IN(rd), .INT_OUT(int_w), .DATA_OUT(data), .DATA_OE_OUT(oe));
    cpva_host_model cpva_host_model_i (.clk_in(ref_clk), .int_in(int_w), .data_in(data), .oe_in(oe),
        .rd_out(rd), .ack_byte_out(ack_b), .vec_byte_out(vec_b), .entry_out(entry), .answers_out(answers));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog, well past the 24 trials of about 15 cycles each
    initial
    begin
        #40000;
        error_cnt++;
        close_out();
    end
    // single levels walk all 16 codes, then random masks test ranking
    initial
    begin
        repeat (8) @(negedge ref_clk);
        rstn = 1'b1;
        for (int t = 0; t < 24; t++)
        begin
            req_n = (t < 16) ? ~(16'h1 << t) : 16'($random(seed));
            if (&req_n) req_n[0] = 1'b0;
            w = 0;
            for (int k = 0; k < 16; k++) if (!req_n[k]) w = k;
            exp_q.push_back({w >= 8, w < 8, 3'(~w), 3'h0});
            prev = answers;
            if (t == 0)
            begin
                repeat (10) @(negedge ref_clk);
                `CHK(int_cnt, 0)
            end
            en = 1'b1;
            for (int n = 0; n < 40 && answers == prev; n++) @(negedge ref_clk);
            exp_vec = exp_q.pop_front();
            `CHK(answers, prev + 1)
            `CHK(ack_b, 8'hff)
            `CHK({2'h0, ack_b[5:3], 3'h0}, 8'h38)
            `CHK(vec_b, exp_vec)
            `CHK(vec_b[2:0], 3'h0)
            `CHK(entry[7:0], exp_vec)
            repeat (6) @(negedge ref_clk);
            `CHK(int_cnt, t + 1)
            `CHK(oe, 1'b0)
            // enable drops first: the latch still holds the served level when the flag clears
            en = 1'b0;
            req_n = 16'hffff;
            status = '{group_select_n: 1'b0, level_n: 3'($random(seed))};
            load_n[t % 2] = 1'b0;
            @(negedge ref_clk);
            load_n = 2'h3;
            repeat (2) @(negedge ref_clk);
            $display("test %0d done", t);
        end
        // stored level 3 in the low group: levels 3 and below stay masked, level 5 gets through
        status = '{group_select_n: 1'b1, level_n: 3'h4};
        load_n = 2'h1;
        @(negedge ref_clk);
        load_n = 2'h3;
        req_n = ~16'h000c;
        en = 1'b1;
        repeat (10) @(negedge ref_clk);
        `CHK(int_cnt, 24)
        prev = answers;
        req_n = ~16'h002c;
        for (int n = 0; n < 40 && answers == prev; n++) @(negedge ref_clk);
        `CHK(vec_b, 8'h50)
        repeat (6) @(negedge ref_clk);
        `CHK(int_cnt, 25)
        $display("test status mask done");
        close_out();
    end
endmodule
